// [include/asod_regs.svh]
// Index, width and bit-position constants for the add and shift operand datapath.
`ifndef ASOD_REGS_SVH
`define ASOD_REGS_SVH
`define ASOD_DEFAULT_WORK_REG_IDX 4'h0
`define ASOD_W8_IDX 4'h8
`define ASOD_W9_IDX 4'h9
`define ASOD_W10_IDX 4'ha
`define ASOD_W11_IDX 4'hb
`define ASOD_W12_IDX 4'hc
`define ASOD_QUAD_HI 2'h1
`define ASOD_STEP_BAD 4'h8
`define ASOD_MODE_DIRECT 3'h0
`define ASOD_ACC_W 40
`define ASOD_ACC_GUARD_LSB 31
`define ASOD_ACC_MAX 40'h7fffffffff
`define ASOD_ACC_MIN 40'h8000000000
`endif

// [include/asod_pkg.sv]
// Types shared by the add and shift operand datapath.
`include "asod_regs.svh"
package asod_pkg;
  typedef enum logic [2:0] {
    ASOD_OP_ADD = 3'b000,
    ASOD_OP_ADD_WITH_CARRY_IN = 3'b001,
    ASOD_OP_AND = 3'b010,
    ASOD_OP_ASR = 3'b011,
    ASOD_OP_ACC_ADD = 3'b100,
    ASOD_OP_ACC_SUM = 3'b101,
    ASOD_OP_MUL = 3'b110,
    ASOD_OP_NOP = 3'b111
  } asod_op_e;
  typedef enum logic [2:0] {
    ASOD_FM_FILE = 3'b000,
    ASOD_FM_FILE_DEFAULT_WORK_REG = 3'b001,
    ASOD_FM_TEN_BIT_LITERAL = 3'b010,
    ASOD_FM_REG3 = 3'b011,
    ASOD_FM_FIVE_BIT_LITERAL = 3'b100,
    ASOD_FM_REG2 = 3'b101
  } asod_form_e;
  typedef enum logic [1:0] {
    ASOD_MK_NONE = 2'b00,
    ASOD_MK_DIV = 2'b01,
    ASOD_MK_SQR = 2'b10,
    ASOD_MK_DSP = 2'b11
  } asod_mulk_e;
  typedef enum logic [1:0] {
    ASOD_PF_NONE = 2'b00,
    ASOD_PF_PLAIN = 2'b01,
    ASOD_PF_POST = 2'b10,
    ASOD_PF_INDEX = 2'b11
  } asod_pf_e;
  typedef struct packed {
    asod_pf_e mode;
    logic reg_hi;
    logic [3:0] step;
    logic [1:0] dst;
    logic [15:0] data;
  } asod_pf_s;
  typedef struct packed {
    logic valid;
    asod_op_e op;
    asod_form_e form;
    logic [3:0] base;
    logic [3:0] src;
    logic [3:0] dst;
    logic [2:0] src_mode;
    logic [9:0] lit;
    logic [15:0] file_data;
    logic acc_b;
    logic [3:0] signed_shift_literal;
    asod_mulk_e mul_kind;
    logic [3:0] mul_m;
    logic [3:0] mul_n;
    asod_pf_s xpf;
    asod_pf_s ypf;
  } asod_cmd_s;
  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic oa;
    logic ob;
    logic sa;
    logic sb;
  } asod_flags_s;
  typedef logic [15:0][15:0] asod_wfile_t;
endpackage

// [src/asod_datapath.sv]
// One-cycle add, AND and arithmetic shift datapath with working registers and sum registers.
//
// Contract
// - Operand fields select any of sixteen registers.
// - Divide operands use direct register addressing only.
// - Square accepts only same register four to seven.
// - Multiply accepts six distinct pairs of four-seven.
// - File operations use register zero as default.
// - X prefetch uses eight or nine, steps, index.
// - Y prefetch uses ten or eleven, steps, index.
// - Prefetched data lands only in registers four-seven.
// - Sum register adds update only four sum flags.
// - File add sums file and default register, five flags.
// - Literal add writes back register, five flags.
// - Three-operand add writes destination, five flags.
// - File shift keeps sign, four flags.
// - Register single shift, shifted bit to carry.
// - Shift by register count updates negative, zero.
// - Shift by literal count updates negative, zero.
`timescale 1ns/1ps
`include "asod_regs.svh"
module asod_datapath import asod_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire asod_cmd_s cmd_i,
  output asod_flags_s flags_o,
  output logic [15:0] result_o,
  output logic file_we_o,
  output logic [15:0] file_wdata_o,
  output logic done_o,
  output logic err_o,
  output logic [15:0] x_addr_o,
  output logic [15:0] y_addr_o,
  output asod_wfile_t w_o,
  output logic [39:0] acc_a_o,
  output logic [39:0] acc_b_o
);
  asod_wfile_t w_q;
  asod_wfile_t w_d;
  logic [39:0] acc_q [2];
  logic [39:0] acc_new;
  asod_flags_s flags_q;
  asod_flags_s flags_d;
  logic [15:0] result_q;
  logic file_we_q;
  logic done_q;
  logic err_q;
  logic [15:0] x_addr_q;
  logic [15:0] y_addr_q;

  // Operand fetch: every selector is a full 4-bit register index.
  wire [15:0] w_base = w_q[cmd_i.base];
  wire [15:0] w_src = w_q[cmd_i.src];
  wire [15:0] w_dst = w_q[cmd_i.dst];
  wire [15:0] w_dflt = w_q[`ASOD_DEFAULT_WORK_REG_IDX];
  wire is_file = (cmd_i.form == ASOD_FM_FILE) || (cmd_i.form == ASOD_FM_FILE_DEFAULT_WORK_REG);
  wire is_add = (cmd_i.op == ASOD_OP_ADD) || (cmd_i.op == ASOD_OP_ADD_WITH_CARRY_IN);
  wire is_and = (cmd_i.op == ASOD_OP_AND);
  wire is_asr = (cmd_i.op == ASOD_OP_ASR);
  wire is_alu = is_add || is_and || is_asr;
  wire is_acc = (cmd_i.op == ASOD_OP_ACC_ADD) || (cmd_i.op == ASOD_OP_ACC_SUM);
  wire asr_multi = is_asr && ((cmd_i.form == ASOD_FM_REG3) || (cmd_i.form == ASOD_FM_FIVE_BIT_LITERAL));

  // The in-place literal form reads and writes the same register.
  wire [15:0] opa = is_file ? cmd_i.file_data :
                    (cmd_i.form == ASOD_FM_TEN_BIT_LITERAL) ? w_dst :
                    (cmd_i.form == ASOD_FM_REG2) ? w_src : w_base;
  wire [15:0] opb = is_file ? w_dflt :
                    (cmd_i.form == ASOD_FM_TEN_BIT_LITERAL) ? {6'h00, cmd_i.lit} :
                    (cmd_i.form == ASOD_FM_FIVE_BIT_LITERAL) ? {11'h000, cmd_i.lit[4:0]} : w_src;
  wire cin = (cmd_i.op == ASOD_OP_ADD_WITH_CARRY_IN) && flags_q.c;
  wire [16:0] sum17 = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin};
  wire [4:0] nib5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  wire add_ov = (opa[15] == opb[15]) && (sum17[15] != opa[15]);
  // Register counts use the low four bits; a literal count may reach 31, which fills with the sign.
  wire [4:0] sh_cnt = (cmd_i.form == ASOD_FM_REG3) ? {1'b0, w_src[3:0]} : cmd_i.lit[4:0];
  wire [15:0] asr_n = 16'($signed(opa) >>> sh_cnt);
  wire [15:0] asr_1 = {opa[15], opa[15:1]};
  wire [15:0] res = is_and ? (opa & opb) : is_asr ? (asr_multi ? asr_n : asr_1) : sum17[15:0];

  // Operand pair legality.
  wire m_hi = (cmd_i.mul_m[3:2] == `ASOD_QUAD_HI);
  wire n_hi = (cmd_i.mul_n[3:2] == `ASOD_QUAD_HI);
  wire div_ok = (cmd_i.src_mode == `ASOD_MODE_DIRECT);
  wire sqr_ok = m_hi && (cmd_i.mul_m == cmd_i.mul_n);
  wire dsp_ok = m_hi && n_hi && (cmd_i.mul_m != cmd_i.mul_n);
  wire mul_ok = (cmd_i.mul_kind == ASOD_MK_NONE) || ((cmd_i.mul_kind == ASOD_MK_DIV) && div_ok) ||
                ((cmd_i.mul_kind == ASOD_MK_SQR) && sqr_ok) || ((cmd_i.mul_kind == ASOD_MK_DSP) && dsp_ok);
  // A post-modify step must be one of +-2, +-4, +-6.
  wire x_step_ok = (cmd_i.xpf.step != 4'h0) && !cmd_i.xpf.step[0] && (cmd_i.xpf.step != `ASOD_STEP_BAD);
  wire y_step_ok = (cmd_i.ypf.step != 4'h0) && !cmd_i.ypf.step[0] && (cmd_i.ypf.step != `ASOD_STEP_BAD);
  wire x_ok = ((cmd_i.xpf.mode != ASOD_PF_POST) || x_step_ok) &&
              ((cmd_i.xpf.mode != ASOD_PF_INDEX) || cmd_i.xpf.reg_hi);
  wire y_ok = ((cmd_i.ypf.mode != ASOD_PF_POST) || y_step_ok) &&
              ((cmd_i.ypf.mode != ASOD_PF_INDEX) || cmd_i.ypf.reg_hi);
  wire legal = mul_ok && x_ok && y_ok;
  wire go = cmd_i.valid && legal;

  // Prefetch addressing; the index form adds register twelve to the upper base register.
  wire [3:0] x_bidx = cmd_i.xpf.reg_hi ? `ASOD_W9_IDX : `ASOD_W8_IDX;
  wire [3:0] y_bidx = cmd_i.ypf.reg_hi ? `ASOD_W11_IDX : `ASOD_W10_IDX;
  wire [15:0] w_idx = w_q[`ASOD_W12_IDX];
  wire [15:0] x_ea = (cmd_i.xpf.mode == ASOD_PF_INDEX) ? 16'(w_q[x_bidx] + w_idx) : w_q[x_bidx];
  wire [15:0] y_ea = (cmd_i.ypf.mode == ASOD_PF_INDEX) ? 16'(w_q[y_bidx] + w_idx) : w_q[y_bidx];
  wire [15:0] x_post = 16'(w_q[x_bidx] + {{12{cmd_i.xpf.step[3]}}, cmd_i.xpf.step});
  wire [15:0] y_post = 16'(w_q[y_bidx] + {{12{cmd_i.ypf.step[3]}}, cmd_i.ypf.step});
  wire x_pf = go && (cmd_i.xpf.mode != ASOD_PF_NONE);
  wire y_pf = go && (cmd_i.ypf.mode != ASOD_PF_NONE);
  // The destination field is two bits wide, so only registers four to seven can be hit.
  wire [3:0] x_didx = {`ASOD_QUAD_HI, cmd_i.xpf.dst};
  wire [3:0] y_didx = {`ASOD_QUAD_HI, cmd_i.ypf.dst};

  // Main result destination.
  wire to_file = go && is_alu && (cmd_i.form == ASOD_FM_FILE);
  wire to_w = go && is_alu && !to_file;
  wire [3:0] wr_idx = is_file ? `ASOD_DEFAULT_WORK_REG_IDX : cmd_i.dst;

  // The ALU result wins over a prefetch load, which wins over a post-modify, on the same register.
  for (genvar i = 0; i < 16; i++) begin : g_default_work_reg
    always_comb begin
      w_d[i] = w_q[i];
      if (x_pf && (cmd_i.xpf.mode == ASOD_PF_POST) && (x_bidx == 4'(i))) begin
        w_d[i] = x_post;
      end
      if (y_pf && (cmd_i.ypf.mode == ASOD_PF_POST) && (y_bidx == 4'(i))) begin
        w_d[i] = y_post;
      end
      if (x_pf && (x_didx == 4'(i))) begin
        w_d[i] = cmd_i.xpf.data;
      end
      if (y_pf && (y_didx == 4'(i))) begin
        w_d[i] = cmd_i.ypf.data;
      end
      if (to_w && (wr_idx == 4'(i))) begin
        w_d[i] = res;
      end
    end
  end

  // Sum register path: the word sits in bits 31:16; a positive shift goes right, negative left.
  wire [39:0] acc_sel = acc_q[cmd_i.acc_b];
  wire [39:0] acc_oth = acc_q[!cmd_i.acc_b];
  wire [39:0] acc_word = {{8{w_src[15]}}, w_src, 16'h0000};
  wire [3:0] sh_left = 4'(-cmd_i.signed_shift_literal);
  wire [39:0] acc_sh = cmd_i.signed_shift_literal[3] ? (acc_word << sh_left) : 40'($signed(acc_word) >>> cmd_i.signed_shift_literal);
  wire [39:0] acc_add = (cmd_i.op == ASOD_OP_ACC_SUM) ? acc_oth : acc_sh;
  wire [40:0] acc_sum41 = {acc_sel[39], acc_sel} + {acc_add[39], acc_add};
  wire acc_ovf = (acc_sum41[40] != acc_sum41[39]);
  // Saturation on 40-bit overflow keeps the sign instead of wrapping.
  assign acc_new = acc_ovf ? (acc_sum41[40] ? `ASOD_ACC_MIN : `ASOD_ACC_MAX) : acc_sum41[39:0];
  wire [39:0] acc_a_n = (go && is_acc && !cmd_i.acc_b) ? acc_new : acc_q[0];
  wire [39:0] acc_b_n = (go && is_acc && cmd_i.acc_b) ? acc_new : acc_q[1];
  wire [8:0] a_guard = acc_a_n[39:`ASOD_ACC_GUARD_LSB];
  wire [8:0] b_guard = acc_b_n[39:`ASOD_ACC_GUARD_LSB];

  always_comb begin
    flags_d = flags_q;
    if (go && is_alu) begin
      flags_d.n = res[15];
      flags_d.z = (res == 16'h0000);
      if (is_add) begin
        flags_d.c = sum17[16];
        flags_d.dc = nib5[4];
        flags_d.ov = add_ov;
      end
      if (is_asr && !asr_multi) begin
        flags_d.c = opa[0];
        flags_d.ov = 1'b0;
      end
    end
    if (go && is_acc) begin
      flags_d.oa = !((&a_guard) || !(|a_guard));
      flags_d.ob = !((&b_guard) || !(|b_guard));
      flags_d.sa = flags_q.sa || (acc_ovf && !cmd_i.acc_b);
      flags_d.sb = flags_q.sb || (acc_ovf && cmd_i.acc_b);
    end
  end

  // Every operation retires on the edge that takes it.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      w_q <= '0;
      acc_q[0] <= '0;
      acc_q[1] <= '0;
      flags_q <= '0;
      result_q <= 16'h0000;
      file_we_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      x_addr_q <= 16'h0000;
      y_addr_q <= 16'h0000;
    end else begin
      w_q <= w_d;
      acc_q[0] <= acc_a_n;
      acc_q[1] <= acc_b_n;
      flags_q <= flags_d;
      result_q <= go && is_alu ? res : result_q;
      file_we_q <= to_file;
      done_q <= go;
      err_q <= cmd_i.valid && !legal;
      x_addr_q <= x_pf ? x_ea : x_addr_q;
      y_addr_q <= y_pf ? y_ea : y_addr_q;
    end
  end

  assign flags_o = flags_q;
  assign result_o = result_q;
  assign file_we_o = file_we_q;
  assign file_wdata_o = result_q;
  assign done_o = done_q;
  assign err_o = err_q;
  assign x_addr_o = x_addr_q;
  assign y_addr_o = y_addr_q;
  assign w_o = w_q;
  assign acc_a_o = acc_q[0];
  assign acc_b_o = acc_q[1];

  chk_done_one_cycle: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_i.valid |=> (done_o != err_o))
    else $error("Accepted command did not retire in one cycle.");
  chk_div_direct_only: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cmd_i.valid && cmd_i.mul_kind == ASOD_MK_DIV && cmd_i.src_mode != 3'h0) |=> err_o && !done_o)
    else $error("Indirect divide operand was not refused.");
  chk_square_pair: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cmd_i.valid && cmd_i.mul_kind == ASOD_MK_SQR && (cmd_i.mul_m != cmd_i.mul_n || cmd_i.mul_m[3:2] != 2'h1))
    |=> err_o)
    else $error("Illegal square pair was accepted.");
  chk_dsp_pair: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cmd_i.valid && cmd_i.mul_kind == ASOD_MK_DSP && cmd_i.mul_m == cmd_i.mul_n) |=> err_o)
    else $error("Repeated multiply register was accepted.");
  chk_x_index_base: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cmd_i.valid && cmd_i.xpf.mode == ASOD_PF_INDEX && !cmd_i.xpf.reg_hi) |=> err_o)
    else $error("Indexed X prefetch on the lower base was accepted.");
  chk_and_keeps_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (go && is_and) |=> (flags_o.c == $past(flags_o.c)) && (flags_o.ov == $past(flags_o.ov))
    && (flags_o.dc == $past(flags_o.dc)) && (flags_o.z == (result_o == 16'h0000)))
    else $error("AND changed carry, nibble carry or overflow.");
  chk_acc_keeps_alu: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (go && is_acc) |=> $stable(flags_o.c) && $stable(flags_o.n) && $stable(flags_o.z) && $stable(result_o))
    else $error("Sum register add touched arithmetic flags.");
  chk_file_add_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (go && cmd_i.op == ASOD_OP_ADD && cmd_i.form == ASOD_FM_FILE) |=> file_we_o
    && (file_wdata_o == 16'($past(cmd_i.file_data) + $past(w_dflt))))
    else $error("File add result or strobe wrong.");
  chk_file_shift_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (go && is_asr && is_file) |=> (flags_o.c == $past(cmd_i.file_data[0])) && !flags_o.ov
    && (result_o[15] == result_o[14]))
    else $error("File shift lost the sign or the carry.");
  chk_multi_shift_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (go && asr_multi) |=> $stable(flags_o.c) && $stable(flags_o.ov) && !file_we_o)
    else $error("Multi-bit shift changed carry or overflow.");
endmodule

// [tb/add_and_shift_operand_datapath_tb_top.sv]
// Self-checking testbench for the add and shift operand datapath.
`timescale 1ns/1ps
`include "asod_regs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module add_and_shift_operand_datapath_tb_top import asod_pkg::*; ();
  typedef struct packed {
    logic err;
    logic fw;
    logic chk;
    logic [15:0] res;
    logic [4:0] fl;
    logic [15:0] xa;
    logic [15:0] ya;
  } asod_exp_s;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  asod_cmd_s cmd_i = '0;
  asod_flags_s flags_o;
  logic [15:0] result_o, file_wdata_o, x_addr_o, y_addr_o;
  logic file_we_o, done_o, err_o;
  asod_wfile_t w_o;
  logic [39:0] acc_a_o, acc_b_o;
  int err_count = 0;
  int n_tests = 0;
  integer seed = 60091;
  asod_exp_s exp_q[$];
  asod_exp_s mon_e;
  logic [15:0] mw [16];
  logic mc = 1'b0, mdc = 1'b0, mn = 1'b0, mov = 1'b0, mz = 1'b0;
  logic [15:0] mxa = 16'h0000, mya = 16'h0000;
  logic [39:0] macc [2];
  logic msa = 1'b0, msb = 1'b0;
  always #5 clk_i = ~clk_i;
  asod_datapath dut (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i), .flags_o(flags_o), .result_o(result_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .done_o(done_o), .err_o(err_o), .x_addr_o(x_addr_o),
    .y_addr_o(y_addr_o), .w_o(w_o), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o));
  // The model runs at issue time, so each note already reflects every earlier command.
  task automatic send(input asod_cmd_s c);
    asod_exp_s e;
    logic [15:0] a, b, r;
    logic [16:0] s;
    logic cin, bad, fl;
    logic [3:0] wd, xb, yb;
    logic [39:0] aw;
    logic [40:0] a41;
    e = '0;
    r = 16'h0000;
    fl = c.form inside {ASOD_FM_FILE, ASOD_FM_FILE_DEFAULT_WORK_REG};
    cin = (c.op == ASOD_OP_ADD_WITH_CARRY_IN) ? mc : 1'b0;
    a = fl ? c.file_data : (c.form == ASOD_FM_TEN_BIT_LITERAL) ? mw[c.dst] : (c.form == ASOD_FM_REG2) ? mw[c.src] : mw[c.base];
    b = fl ? mw[`ASOD_DEFAULT_WORK_REG_IDX] : (c.form == ASOD_FM_TEN_BIT_LITERAL) ? {6'h00, c.lit} :
        (c.form == ASOD_FM_FIVE_BIT_LITERAL) ? {11'h000, c.lit[4:0]} : mw[c.src];
    wd = (c.form == ASOD_FM_FILE_DEFAULT_WORK_REG) ? `ASOD_DEFAULT_WORK_REG_IDX : c.dst;
    bad = (c.op == ASOD_OP_MUL) && ((c.mul_kind == ASOD_MK_DIV && c.src_mode != 3'h0) ||
          (c.mul_kind == ASOD_MK_SQR && (c.mul_m != c.mul_n || c.mul_m[3:2] != 2'h1)) ||
          (c.mul_kind == ASOD_MK_DSP && (c.mul_m == c.mul_n || c.mul_m[3:2] != 2'h1 || c.mul_n[3:2] != 2'h1)));
    // A post step must be +-2, +-4 or +-6 in four-bit two's complement; the index form needs the upper base.
    bad = bad || (c.xpf.mode == ASOD_PF_POST && !(c.xpf.step inside {4'h2, 4'h4, 4'h6, 4'ha, 4'hc, 4'he})) ||
          (c.xpf.mode == ASOD_PF_INDEX && !c.xpf.reg_hi) ||
          (c.ypf.mode == ASOD_PF_POST && !(c.ypf.step inside {4'h2, 4'h4, 4'h6, 4'ha, 4'hc, 4'he})) ||
          (c.ypf.mode == ASOD_PF_INDEX && !c.ypf.reg_hi);
    case (c.op)
      ASOD_OP_ADD, ASOD_OP_ADD_WITH_CARRY_IN: begin
        s = {1'b0, a} + {1'b0, b} + 17'(cin);
        r = s[15:0];
        mc = s[16];
        mdc = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(cin)) > 5'h0f;
        mov = (a[15] == b[15]) && (r[15] != a[15]);
      end
      ASOD_OP_AND: r = a & b;
      ASOD_OP_ASR: begin
        if (c.form inside {ASOD_FM_REG3, ASOD_FM_FIVE_BIT_LITERAL}) begin
          r = 16'($signed(a) >>> ((c.form == ASOD_FM_FIVE_BIT_LITERAL) ? b[4:0] : {1'b0, b[3:0]}));
        end else begin
          r = {a[15], a[15:1]};
          mc = a[0];
          mov = 1'b0;
        end
      end
      ASOD_OP_ACC_ADD, ASOD_OP_ACC_SUM: if (!bad) begin
        aw = {{8{mw[c.src][15]}}, mw[c.src], 16'h0000};
        aw = c.signed_shift_literal[3] ? (aw << 4'(-c.signed_shift_literal)) : 40'($signed(aw) >>> c.signed_shift_literal);
        if (c.op == ASOD_OP_ACC_SUM) aw = macc[!c.acc_b];
        a41 = {macc[c.acc_b][39], macc[c.acc_b]} + {aw[39], aw};
        if (a41[40] != a41[39]) begin
          macc[c.acc_b] = a41[40] ? `ASOD_ACC_MIN : `ASOD_ACC_MAX;
          if (c.acc_b) msb = 1'b1;
          else msa = 1'b1;
        end else begin
          macc[c.acc_b] = a41[39:0];
        end
      end
      default: ;
    endcase
    // Prefetch: addresses use the old registers, post-modify next, loads win over post-modify.
    if (!bad) begin
      xb = c.xpf.reg_hi ? `ASOD_W9_IDX : `ASOD_W8_IDX;
      yb = c.ypf.reg_hi ? `ASOD_W11_IDX : `ASOD_W10_IDX;
      if (c.xpf.mode != ASOD_PF_NONE) mxa = (c.xpf.mode == ASOD_PF_INDEX) ? 16'(mw[xb] + mw[12]) : mw[xb];
      if (c.ypf.mode != ASOD_PF_NONE) mya = (c.ypf.mode == ASOD_PF_INDEX) ? 16'(mw[yb] + mw[12]) : mw[yb];
      if (c.xpf.mode == ASOD_PF_POST) mw[xb] = 16'(mw[xb] + {{12{c.xpf.step[3]}}, c.xpf.step});
      if (c.ypf.mode == ASOD_PF_POST) mw[yb] = 16'(mw[yb] + {{12{c.ypf.step[3]}}, c.ypf.step});
      if (c.xpf.mode != ASOD_PF_NONE) mw[4 + c.xpf.dst] = c.xpf.data;
      if (c.ypf.mode != ASOD_PF_NONE) mw[4 + c.ypf.dst] = c.ypf.data;
    end
    if (c.op inside {ASOD_OP_ADD, ASOD_OP_ADD_WITH_CARRY_IN, ASOD_OP_AND, ASOD_OP_ASR}) begin
      mn = r[15];
      mz = (r == 16'h0000);
      e.chk = 1'b1;
      e.fw = (c.form == ASOD_FM_FILE);
      if (c.form != ASOD_FM_FILE) mw[wd] = r;
    end
    e.err = bad;
    e.xa = mxa;
    e.ya = mya;
    e.res = r;
    e.fl = {mc, mdc, mn, mov, mz};
    exp_q.push_back(e);
    @(posedge clk_i);
    cmd_i <= c;
  endtask
  always @(negedge clk_i) begin
    if (rstn_i && (done_o || err_o)) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("CHECK FAILED completion with no command outstanding");
      end else begin
        mon_e = exp_q.pop_front();
        `CHK("err", mon_e.err, err_o)
        `CHK("done", !mon_e.err, done_o)
        `CHK("file_we", mon_e.fw, file_we_o)
        `CHK("flags", mon_e.fl, {flags_o.c, flags_o.dc, flags_o.n, flags_o.ov, flags_o.z})
        if (mon_e.chk) `CHK("result", mon_e.res, result_o)
        if (mon_e.fw) `CHK("file data", mon_e.res, file_wdata_o)
        `CHK("x addr", mon_e.xa, x_addr_o)
        `CHK("y addr", mon_e.ya, y_addr_o)
      end
    end
  end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    asod_cmd_s c;
    for (int i = 0; i < 16; i++) mw[i] = 16'h0000;
    macc[0] = 40'h0000000000;
    macc[1] = 40'h0000000000;
    repeat (8) @(posedge clk_i);
    `CHK("w reset", 256'h0, w_o)
    rstn_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      c = '0;
      c.valid = 1'b1;
      c.form = ASOD_FM_TEN_BIT_LITERAL;
      c.dst = 4'(i);
      c.lit = 10'($random(seed));
      send(c);
    end
    for (int i = 0; i < 600; i++) begin
      c = '0;
      c.valid = 1'b1;
      c.op = asod_op_e'(3'($unsigned($random(seed)) % 4));
      c.form = asod_form_e'(3'($unsigned($random(seed)) % 5));
      if (c.op == ASOD_OP_ASR && c.form == ASOD_FM_TEN_BIT_LITERAL) c.form = ASOD_FM_REG2;
      c.base = 4'($random(seed));
      c.src = 4'($random(seed));
      c.dst = 4'($random(seed));
      c.lit = 10'($random(seed));
      c.file_data = 16'($random(seed));
      send(c);
    end
    // Every square and multiply pair plus every divide addressing mode, with a prefetch riding along.
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 16; m++) begin
        for (int n = 0; n < 16; n++) begin
          c = '0;
          c.valid = 1'b1;
          c.op = ASOD_OP_MUL;
          c.mul_kind = (k == 0) ? ASOD_MK_SQR : (k == 1) ? ASOD_MK_DSP : ASOD_MK_DIV;
          c.src_mode = 3'(n);
          c.mul_m = 4'(m);
          c.mul_n = 4'(n);
          c.xpf = {ASOD_PF_PLAIN, 1'($random(seed)), 4'h0, 2'($random(seed)), 16'($random(seed))};
          c.ypf = {ASOD_PF_PLAIN, 1'($random(seed)), 4'h0, 2'($random(seed)), 16'($random(seed))};
          if (k < 2 || (m == 0 && n < 8)) send(c);
        end
      end
    end
    // Sum register adds and idle commands carrying every prefetch mode, legal steps and refused ones alike.
    for (int i = 0; i < 300; i++) begin
      c = '0;
      c.valid = 1'b1;
      c.op = (i % 3 == 0) ? ASOD_OP_NOP : (i % 3 == 1) ? ASOD_OP_ACC_ADD : ASOD_OP_ACC_SUM;
      c.src = 4'($random(seed));
      c.acc_b = 1'($random(seed));
      c.signed_shift_literal = 4'($random(seed));
      c.xpf = {asod_pf_e'(2'($random(seed))), 1'($random(seed)), 4'($random(seed)), 2'($random(seed)),
               16'($random(seed))};
      c.ypf = {asod_pf_e'(2'($random(seed))), 1'($random(seed)), 4'($random(seed)), 2'($random(seed)),
               16'($random(seed))};
      send(c);
    end
    @(posedge clk_i);
    cmd_i <= '0;
    for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge clk_i);
    if (exp_q.size() != 0) begin
      err_count++;
      $display("CHECK FAILED completions missing at end of run");
    end
    @(negedge clk_i);
    for (int i = 0; i < 16; i++) `CHK("w file", mw[i], w_o[i])
    `CHK("acc a", macc[0], acc_a_o)
    `CHK("acc b", macc[1], acc_b_o)
    `CHK("sum flags", {!((&macc[0][39:31]) || !(|macc[0][39:31])), !((&macc[1][39:31]) || !(|macc[1][39:31])), msa, msb}, {flags_o.oa, flags_o.ob, flags_o.sa, flags_o.sb})
    close_out();
  end
endmodule
